// ===== hw/ccs_regs.sv
// Purpose : Control and status register pair of a single-cell charger
// Assumes : I2C front end turns bus cycles into one-cycle read and write strobes
// Notes   : Analog loops live outside; this block steers them and reports their state
//
// Overview of operation
// - Detect request starts detection while input is present, clears when done
// - Half-rate bit halves safety timer in slow conditions
// - Disable bit turns battery switch off
// - Delay bit adds ship-mode wait before turn-off
// - Warm band caps charge voltage unless selected
// - Reset-enable bit gates full system reset requests
// - Tracking picks max of limit and battery+offset
// - Source status codes none, USB, adapter, OTG
// - Charge state codes disabled, pre, fast, done
// - Power good bit reports valid strong input
// - Thermal bit reports thermal regulation
// - System bit reports minimum system regulation
// - Status register read only, live values
// - Control register at 0x07, power-up 01001100
// - Register reset restores defaults, resets timer
`timescale 1ns/1ps
`default_nettype none

module ccs_regs
  import ccs_pkg::*;
#(
  parameter int unsigned SHIP_DELAY_CYCLES = SHIP_DELAY_CYC  // Shorten for simulation
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire ccs_req_t    i_req,
  input  wire ccs_status_t i_status,
  input  wire ccs_cond_t   i_cond,
  input  wire logic        i_detect_done,
  input  wire logic        i_timer_tick,
  input  wire logic        i_full_reset_req,
  input  wire logic        i_reg_reset,
  input  wire logic        i_watchdog_expired,
  input  wire logic [15:0] i_input_voltage_limit_mv,
  input  wire logic [15:0] i_vbat_mv,
  input  wire logic [15:0] i_charge_voltage_setting_mv,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic             o_detect_active,
  output logic             o_timer_tick,
  output logic             o_battery_switch_on,
  output logic             o_system_reset,
  output logic             o_safety_timer_reset,
  output logic             o_reg_reset_done,
  output logic [15:0]      o_input_voltage_limit_mv,
  output logic [15:0]      o_charge_voltage_mv
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  ctrl;        // Control register contents
    logic [31:0] ship_cnt;    // Ship-mode delay counter
    logic        sw_on;       // Battery switch gate
    logic        half_ph;     // Half-rate tick phase
    logic        tick;        // Forwarded timer tick
    logic        sys_rst;     // System reset pulse
    logic        tmr_rst;     // Safety timer reset pulse
    logic        rst_done;    // Register reset complete pulse
    logic        detect;      // Detection running
    logic [7:0]  rdata;       // Read data
    logic        rvalid;      // Read data valid
    logic [15:0] vlim;        // Effective input voltage limit
    logic [15:0] vchg;        // Effective charge voltage
  } ccs_state_t;

  ccs_state_t state_q;   // Registered state
  ccs_state_t state_d;   // Next state

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Larger of two millivolt values
  function automatic logic [15:0] max_mv(input logic [15:0] a, input logic [15:0] b);
    max_mv = (a > b) ? a : b;
  endfunction

  // Smaller of two millivolt values
  function automatic logic [15:0] min_mv(input logic [15:0] a, input logic [15:0] b);
    min_mv = (a < b) ? a : b;
  endfunction

  // Offset in millivolts for a tracking code
  function automatic logic [15:0] track_ofs(input logic [1:0] code);
    case (code)
      2'h1:    track_ofs = TRACK_OFS1_MV;
      2'h2:    track_ofs = TRACK_OFS2_MV;
      2'h3:    track_ofs = TRACK_OFS3_MV;
      default: track_ofs = 16'h0000;
    endcase
  endfunction

  // Status byte from live analog state
  function automatic logic [7:0] status_byte(input ccs_status_t s);
    status_byte = {s.input_source_status,
                   s.charge_state,
                   s.power_good_status,
                   s.thermal_reg_status,
                   s.sysmin_reg_status};
  endfunction

  logic        wr_ctrl;     // Host write to control register
  logic [1:0]  track_code;  // Current tracking field
  logic        slow_cond;   // Conditions that slow the safety timer
  logic [15:0] vbat_ofs;    // Battery voltage plus tracking offset
  logic [31:0] ship_limit;  // Ship delay count at counter width

  assign ship_limit = 32'(SHIP_DELAY_CYCLES);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    state_d    = state_q;
    wr_ctrl    = i_req.wr && (i_req.addr == ADDR_MISC_CTRL);
    track_code = state_q.ctrl[TRACK_MSB:TRACK_LSB];
    slow_cond  = i_cond.in_dpm || i_cond.cool_charge || i_status.thermal_reg_status;
    vbat_ofs   = 16'(i_vbat_mv + track_ofs(track_code));

    // Pulses default low
    state_d.tick     = 1'b0;
    state_d.sys_rst  = 1'b0;
    state_d.tmr_rst  = 1'b0;
    state_d.rst_done = 1'b0;
    state_d.rvalid   = 1'b0;

    // Host write; status address ignores writes
    if (wr_ctrl) begin
      state_d.ctrl = i_req.wdata;
    end

    // Detection finished clears the request; a same-cycle write of 1 wins
    if (i_detect_done && !(wr_ctrl && i_req.wdata[BIT_DETECT_REQ])) begin
      state_d.ctrl[BIT_DETECT_REQ] = 1'b0;
    end

    // Watchdog expiry returns its subset to defaults
    if (i_watchdog_expired) begin
      state_d.ctrl = (state_d.ctrl & ~WDOG_RESET_MASK)
                   | (MISC_CTRL_RESET & WDOG_RESET_MASK);
    end

    // Register reset returns every bit and restarts the safety timer
    if (i_reg_reset) begin
      state_d.ctrl     = MISC_CTRL_RESET;
      state_d.tmr_rst  = 1'b1;
      state_d.rst_done = 1'b1;
    end

    // Detection runs while request stands and input is present
    state_d.detect = state_d.ctrl[BIT_DETECT_REQ] && i_cond.vbus_present;

    // Safety timer tick, every second one dropped in slow conditions while the half-rate bit is set
    if (i_timer_tick) begin
      if (state_q.ctrl[BIT_HALF_RATE] && slow_cond) begin
        state_d.half_ph = !state_q.half_ph;
        state_d.tick    = state_q.half_ph;
      end else begin
        state_d.tick    = 1'b1;
      end
    end

    // Battery switch with optional ship-mode delay
    if (!state_q.ctrl[BIT_SW_DISABLE]) begin
      state_d.sw_on    = 1'b1;
      state_d.ship_cnt = 32'h0000_0000;
    end else if (!state_q.ctrl[BIT_SW_DELAY]) begin
      state_d.sw_on    = 1'b0;
    end else if (state_q.ship_cnt >= ship_limit - 32'h0000_0001) begin
      state_d.sw_on    = 1'b0;
    end else begin
      state_d.ship_cnt = state_q.ship_cnt + 32'h0000_0001;
    end

    // Full system reset only when allowed
    state_d.sys_rst = i_full_reset_req && state_q.ctrl[BIT_SW_RST_EN];

    // Effective input voltage limit
    if (track_code == 2'h0) begin
      state_d.vlim = i_input_voltage_limit_mv;
    end else begin
      state_d.vlim = max_mv(i_input_voltage_limit_mv, vbat_ofs);
    end

    // Charge voltage in the warm band
    if (i_cond.warm_band && !state_q.ctrl[BIT_WARM_VSEL]) begin
      state_d.vchg = min_mv(i_charge_voltage_setting_mv, WARM_VMAX_MV);
    end else begin
      state_d.vchg = i_charge_voltage_setting_mv;
    end

    // Register reads; status is sampled live
    if (i_req.rd) begin
      state_d.rvalid = 1'b1;
      if (i_req.addr == ADDR_MISC_CTRL) begin
        state_d.rdata = state_q.ctrl;
      end else if (i_req.addr == ADDR_STATUS) begin
        state_d.rdata = status_byte(i_status);
      end else begin
        state_d.rdata = 8'h00;                                     // Unmapped reads zero
      end
    end
  end

  // ==========================================================================
  // State register, frozen while clock enable is low
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q          <= '0;
      state_q.ctrl     <= MISC_CTRL_RESET;
      state_q.sw_on    <= 1'b1;
      state_q.vlim     <= 16'h0000;
      state_q.vchg     <= 16'h0000;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign o_rdata                  = state_q.rdata;
  assign o_rvalid                 = state_q.rvalid;
  assign o_detect_active          = state_q.detect;
  assign o_timer_tick             = state_q.tick;
  assign o_battery_switch_on      = state_q.sw_on;
  assign o_system_reset           = state_q.sys_rst;
  assign o_safety_timer_reset     = state_q.tmr_rst;
  assign o_reg_reset_done         = state_q.rst_done;
  assign o_input_voltage_limit_mv = state_q.vlim;
  assign o_charge_voltage_mv      = state_q.vchg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_detect_clear;
    i_ce && i_detect_done && !i_req.wr && !i_reg_reset |=> !state_q.ctrl[BIT_DETECT_REQ];
  endproperty
  a_detect_clear: assert property (p_detect_clear) else $error("detect req kept");

  property p_half_rate;
    i_ce && i_timer_tick && state_q.ctrl[BIT_HALF_RATE] && slow_cond && !state_q.half_ph
      |=> !o_timer_tick;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("tick not halved");

  property p_switch_on;
    i_ce && !state_q.ctrl[BIT_SW_DISABLE] |=> o_battery_switch_on;
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switch off while allowed");

  property p_switch_now;
    i_ce && state_q.ctrl[BIT_SW_DISABLE] && !state_q.ctrl[BIT_SW_DELAY]
      |=> !o_battery_switch_on;
  endproperty
  a_switch_now: assert property (p_switch_now) else $error("late turn-off");

  property p_switch_wait;
    $fell(o_battery_switch_on) && $past(state_q.ctrl[BIT_SW_DELAY])
      |-> $past(state_q.ship_cnt) >= ship_limit - 32'h0000_0001;
  endproperty
  a_switch_wait: assert property (p_switch_wait) else $error("turn-off before delay");

  property p_warm_cap;
    i_ce && i_cond.warm_band && !state_q.ctrl[BIT_WARM_VSEL]
      |=> o_charge_voltage_mv <= WARM_VMAX_MV;
  endproperty
  a_warm_cap: assert property (p_warm_cap) else $error("warm cap exceeded");

  property p_sys_rst;
    o_system_reset |-> $past(state_q.ctrl[BIT_SW_RST_EN]) && $past(i_full_reset_req);
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("reset not gated");

  property p_track;
    i_ce && track_code == 2'h0 |=> o_input_voltage_limit_mv == $past(i_input_voltage_limit_mv);
  endproperty
  a_track: assert property (p_track) else $error("untracked limit wrong");

  property p_status_rd;
    i_ce && i_req.rd && i_req.addr == ADDR_STATUS
      |=> o_rvalid && o_rdata == $past(status_byte(i_status));
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_reg_reset;
    i_ce && i_reg_reset |=> state_q.ctrl == MISC_CTRL_RESET && o_safety_timer_reset;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("register reset failed");

  property p_wdog_keep;
    i_ce && i_watchdog_expired && !i_reg_reset && !wr_ctrl
      |=> (state_q.ctrl & ~WDOG_RESET_MASK) == ($past(state_q.ctrl) & ~WDOG_RESET_MASK);
  endproperty
  a_wdog_keep: assert property (p_wdog_keep) else $error("watchdog hit kept bits");

  c_detect:   cover property (o_detect_active ##[1:20] !o_detect_active);
  c_ship_off: cover property ($fell(o_battery_switch_on));
  c_sys_rst:  cover property (o_system_reset);

endmodule

`default_nettype wire

// ===== hw/ccs_pkg.sv
// Purpose : Shared constants and carrier types for the charger control and status registers
// Assumes : Single 40 MHz clock, register port driven by an I2C front end
// Notes   : Every offset, field position, reset value and timing count is named here
`default_nettype none

package ccs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 40_000_000;      // Core clock rate
  localparam int unsigned SHIP_DELAY_S    = 8;               // Nominal ship-mode delay, seconds
  localparam int unsigned SHIP_DELAY_CYC  = SHIP_DELAY_S * CLK_HZ; // Cycles in that delay

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_MISC_CTRL   = 8'h07;           // Control register
  localparam logic [7:0] ADDR_STATUS      = 8'h08;           // Status register, read only
  localparam logic [7:0] MISC_CTRL_RESET  = 8'h4C;           // Power-up value 01001100

  // Control field positions
  localparam int unsigned BIT_DETECT_REQ  = 7;               // Input limit detection request
  localparam int unsigned BIT_HALF_RATE   = 6;               // Half-rate safety timer enable
  localparam int unsigned BIT_SW_DISABLE  = 5;               // Battery switch disable
  localparam int unsigned BIT_WARM_VSEL   = 4;               // Warm band voltage select
  localparam int unsigned BIT_SW_DELAY    = 3;               // Battery switch turn-off delay
  localparam int unsigned BIT_SW_RST_EN   = 2;               // Battery switch reset enable
  localparam int unsigned TRACK_LSB       = 0;               // Input limit tracking field low
  localparam int unsigned TRACK_MSB       = 1;               // Input limit tracking field high

  // Bits that also fall back to defaults on watchdog expiry
  localparam logic [7:0] WDOG_RESET_MASK  = 8'hD4;           // Bits 7, 6, 4, 2

  // ==========================================================================
  // Status field codes
  // ==========================================================================
  localparam logic [2:0] SRC_NONE         = 3'h0;            // No input
  localparam logic [2:0] SRC_USB_HOST     = 3'h1;            // Standard USB host port
  localparam logic [2:0] SRC_ADAPTER      = 3'h2;            // Wall adapter
  localparam logic [2:0] SRC_OTG          = 3'h7;            // Boost output active
  localparam logic [1:0] CHG_DISABLED     = 2'h0;            // Charging disabled
  localparam logic [1:0] CHG_PRECHARGE    = 2'h1;            // Pre-charge
  localparam logic [1:0] CHG_FAST         = 2'h2;            // Fast charge
  localparam logic [1:0] CHG_DONE         = 2'h3;            // Terminated

  // ==========================================================================
  // Analog limits, millivolts
  // ==========================================================================
  localparam logic [15:0] WARM_VMAX_MV    = 16'h1004;        // 4.1 V cap in warm band
  localparam logic [15:0] TRACK_OFS1_MV   = 16'h0064;        // Tracking offset code 01
  localparam logic [15:0] TRACK_OFS2_MV   = 16'h0096;        // Tracking offset code 10
  localparam logic [15:0] TRACK_OFS3_MV   = 16'h00C8;        // Tracking offset code 11

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic       wr;      // Write strobe, one cycle
    logic       rd;      // Read strobe, one cycle
    logic [7:0] addr;    // Register address
    logic [7:0] wdata;   // Write data
  } ccs_req_t;

  typedef struct packed {
    logic [2:0] input_source_status;
    logic [1:0] charge_state;
    logic       power_good_status;
    logic       thermal_reg_status;
    logic       sysmin_reg_status;
  } ccs_status_t;

  typedef struct packed {
    logic        in_dpm;        // Dynamic power management active
    logic        cool_charge;   // Cool-band charging
    logic        warm_band;     // Battery in warm band
    logic        vbus_present;  // Input supply present
  } ccs_cond_t;

endpackage

`default_nettype wire

// ===== bench/ccs_host_model.sv
// Purpose : Host-side register master for the charger control and status pair
// Assumes : I2C front end already turns bus cycles into one-cycle strobes
// Notes   : Idle address and data are inverted so stale values never help the design
`timescale 1ns/1ps
`default_nettype none

module ccs_host_model
  import ccs_pkg::*;
(
  input  wire logic       i_clk,
  output var  ccs_req_t   o_req,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  // ==========================================================================
  // Access tasks
  // ==========================================================================
  initial o_req = '0;

  // One-cycle write strobe; fields scrambled once released
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #2;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) #2;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One-cycle read strobe; answer awaited under a small bound
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge i_clk) #2;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
    @(posedge i_clk) #2;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: a};
    for (int i = 0; i < 4; i++) begin
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
        break;
      end
      @(posedge i_clk) #2;
    end
  endtask
endmodule

`default_nettype wire

// ===== bench/ccs_regs_bench.sv
// Purpose : Self-checking bench for the charger control and status registers
// Assumes : Ship delay shortened to 16 cycles; inputs move 2 ns after the edge
// Notes   : Expected values come from the package constants, never from the design
`timescale 1ns/1ps
`default_nettype none

module ccs_regs_bench
  import ccs_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int unsigned SHIP = 16;         // Short ship delay keeps the run brief
  logic        i_clk, i_reset_n;
  logic        done, ttk, frq, rrq, wdq;     // Event pulses into the block
  logic        ce;                           // Clock enable into the block
  ccs_req_t    req;                          // Driven by the host model
  ccs_status_t st;                           // Live status levels
  ccs_cond_t   cond;                         // Operating conditions
  logic [15:0] vlim, vbat, vset;             // Analog settings, mV
  logic [7:0]  rdata, d;
  logic        rvalid, det, ttk_o, sw_on, sys_rst, tmr_rst, rr_done, ok;
  logic [15:0] vlim_o, vchg;
  int          n_fail, compares, c;
  logic [15:0] ofs [4];                      // Tracking offsets by code
  logic [7:0]  stv [4];                      // Status patterns to walk through

  // ==========================================================================
  // Clock and instances
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  ccs_host_model host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

  ccs_regs #(.SHIP_DELAY_CYCLES(SHIP)) dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce), .i_req(req), .i_status(st),
    .i_cond(cond), .i_detect_done(done), .i_timer_tick(ttk), .i_full_reset_req(frq),
    .i_reg_reset(rrq), .i_watchdog_expired(wdq), .i_input_voltage_limit_mv(vlim),
    .i_vbat_mv(vbat), .i_charge_voltage_setting_mv(vset), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_detect_active(det), .o_timer_tick(ttk_o),
    .o_battery_switch_on(sw_on), .o_system_reset(sys_rst),
    .o_safety_timer_reset(tmr_rst), .o_reg_reset_done(rr_done),
    .o_input_voltage_limit_mv(vlim_o), .o_charge_voltage_mv(vchg));

  // ==========================================================================
  // Compare and helper tasks
  // ==========================================================================
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_mv(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t mV got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask

  // Step to 2 ns past the next rising edge
  task automatic tick();
    @(posedge i_clk) #2;
  endtask

  // Read a register and compare, a lost answer counts as a mismatch
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, d, ok);
    chk_bit(ok, 1'b1);
    chk_byte(d, e);
  endtask

  // Four raw ticks, count how many pass the rate scaler
  task automatic ticks4();
    c = 0;
    repeat (4) begin
      tick();
      ttk = 1'b1;
      tick();
      ttk = 1'b0;
      if (ttk_o === 1'b1) c++;
    end
  endtask

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    final_report();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {i_reset_n, done, ttk, frq, rrq, wdq} = '0;
    ce = 1'b1;
    n_fail = 0;
    compares = 0;
    ofs = '{16'h0000, TRACK_OFS1_MV, TRACK_OFS2_MV, TRACK_OFS3_MV};
    stv = '{{SRC_NONE, CHG_DISABLED, 3'h0}, {SRC_USB_HOST, CHG_PRECHARGE, 3'h5},
            {SRC_ADAPTER, CHG_FAST, 3'h2}, {SRC_OTG, CHG_DONE, 3'h7}};
    st = stv[0];
    cond = '0;
    vlim = 16'h1194;                         // 4500 mV
    vbat = 16'h1130;                         // 4400 mV
    vset = 16'h1068;                         // 4200 mV
    repeat (20) @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    chk_bit(sw_on, 1'b1);
    rd(ADDR_MISC_CTRL, MISC_CTRL_RESET);
    // Tracking codes against battery plus offset
    for (int k = 0; k < 4; k++) begin
      host.write_reg(ADDR_MISC_CTRL, MISC_CTRL_RESET | 8'(k));
      tick();
      chk_mv(vlim_o, (k == 0 || vlim > vbat + ofs[k]) ? vlim : vbat + ofs[k]);
    end
    // Warm band cap and its bypass
    cond.warm_band = 1'b1;
    host.write_reg(ADDR_MISC_CTRL, 8'h5C);
    tick();
    chk_mv(vchg, vset);
    host.write_reg(ADDR_MISC_CTRL, MISC_CTRL_RESET);
    tick();
    chk_mv(vchg, WARM_VMAX_MV);
    cond.warm_band = 1'b0;
    // Full system reset gated by enable bit
    for (int k = 1; k >= 0; k--) begin
      host.write_reg(ADDR_MISC_CTRL, k ? 8'h4C : 8'h48);
      tick();
      frq = 1'b1;
      tick();
      frq = 1'b0;
      chk_bit(sys_rst, 1'(k));
    end
    // Timer rate: slow condition halves, normal and disabled pass all
    cond.in_dpm = 1'b1;
    ticks4();
    chk_byte(8'(c), 8'h02);
    cond.in_dpm = 1'b0;
    ticks4();
    chk_byte(8'(c), 8'h04);
    cond.cool_charge = 1'b1;
    host.write_reg(ADDR_MISC_CTRL, 8'h08);
    ticks4();
    chk_byte(8'(c), 8'h04);
    cond.cool_charge = 1'b0;
    // Detection request and self-clear
    cond.vbus_present = 1'b1;
    host.write_reg(ADDR_MISC_CTRL, 8'hC8);
    tick();
    chk_bit(det, 1'b1);
    done = 1'b1;
    tick();
    done = 1'b0;
    tick();
    chk_bit(det, 1'b0);
    rd(ADDR_MISC_CTRL, 8'h48);
    // Battery switch: immediate off, back on, then delayed off
    host.write_reg(ADDR_MISC_CTRL, 8'h60);
    tick();
    chk_bit(sw_on, 1'b0);
    host.write_reg(ADDR_MISC_CTRL, 8'h40);
    tick();
    chk_bit(sw_on, 1'b1);
    host.write_reg(ADDR_MISC_CTRL, 8'h68);
    // Still on one cycle before the delay runs out, off exactly at its end
    repeat (SHIP - 1) tick();
    chk_bit(sw_on, 1'b1);
    tick();
    chk_bit(sw_on, 1'b0);
    // Watchdog keeps its excluded bits, register reset restores all
    host.write_reg(ADDR_MISC_CTRL, 8'hBB);
    tick();
    wdq = 1'b1;
    tick();
    wdq = 1'b0;
    rd(ADDR_MISC_CTRL, 8'hBB & ~WDOG_RESET_MASK | MISC_CTRL_RESET & WDOG_RESET_MASK);
    rrq = 1'b1;
    tick();
    rrq = 1'b0;
    chk_bit(rr_done, 1'b1);
    chk_bit(tmr_rst, 1'b1);
    rd(ADDR_MISC_CTRL, MISC_CTRL_RESET);
    // Live status codes, write ignored, unmapped places
    for (int k = 0; k < 4; k++) begin
      st = stv[k];
      rd(ADDR_STATUS, stv[k]);
    end
    host.write_reg(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, stv[3]);
    host.write_reg(8'h09, 8'h00);
    rd(8'h09, 8'h00);
    // Clock enable low freezes the block, so this write must be lost
    ce = 1'b0;
    host.write_reg(ADDR_MISC_CTRL, 8'h00);
    ce = 1'b1;
    rd(ADDR_MISC_CTRL, MISC_CTRL_RESET);
    final_report();
  end
endmodule

`default_nettype wire
